// ### dce_pkg.sv
// Purpose: Constants and types for the eight-channel DMA engine.
// Assumes: APB register access, one shared system bus master port.
// Notes: Functional notes follow.
// Functional notes
// - Each channel counts items, up to 65535, minus one per completed transaction.
// - Peripheral and memory item widths are chosen independently per channel.
// - Enabled side steps its address by 1, 2 or 4 per item width.
// - First item uses the base addresses; base registers keep their values.
// - Working addresses are internal and not visible to software.
// - Without wraparound, a channel at zero count serves no requests.
// - Disabling a channel keeps its control and base registers.
// - Wraparound reloads the count with the programmed value and continues.
// - Wraparound also reloads both working addresses from the base registers.
// - A two-bit priority level per channel steers arbitration.
// - Control holds direction, wraparound, steps, widths and interrupt enables.
// - An enabled channel with a nonzero count serves any request from its own peripheral.
// - Half of the items moved sets the half-done flag and interrupt.
// - End of transfer sets the full-done flag and interrupt.
// - Memory copy mode starts as soon as the channel is enabled.
// - Memory copy mode stops when the count reaches zero.
// - Byte to halfword: zero-extend, destination steps by two.
// - Byte to word: zero-extend, destination steps by four.
// - Halfword to byte: keep the low byte, destination steps by one.
// - Acknowledge when the channel wins and its read starts (none in copy mode), dropped only after request removal.
// - Equal priority levels go to the lower channel number.
// - Half-done and full-done are ORed into one interrupt per channel.
// - Eight channels, each with its own request input.
`default_nettype none

package dce_pkg;
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int CNT_W = 16;
    localparam int AW = 12;

    // Register map (byte addresses)
    localparam logic [AW-1:0] CH_SPAN_LIMIT = 12'h080;
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_PBASE = 2'h1;
    localparam logic [1:0] REG_MBASE = 2'h2;
    localparam logic [1:0] REG_COUNT = 2'h3;
    localparam logic [AW-1:0] ADDR_STATUS = 12'h080;
    localparam logic [AW-1:0] ADDR_CLEAR = 12'h084;
    localparam int CH_LSB = 4;
    localparam int REG_LSB = 2;
    localparam int HALF_LSB = 8;

    // Item widths
    localparam logic [1:0] WID_BYTE = 2'h0;
    localparam logic [1:0] WID_HALF = 2'h1;
    localparam logic [1:0] WID_WORD = 2'h2;

    // Channel control layout, bit 0 at the bottom
    typedef struct packed {
        logic memory_copy_mode;
        logic [1:0] priority_level;
        logic [1:0] mem_width;
        logic [1:0] periph_width;
        logic mem_addr_step;
        logic periph_addr_step;
        logic wraparound_on;
        logic from_memory;
        logic spare;
        logic half_done_irq_on;
        logic full_done_irq_on;
        logic enable;
    } dce_ctrl_t;

    localparam int CTRL_W = 15;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;

    // One system bus request
    typedef struct packed {
        logic req;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dce_bus_req_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_READ = 3'b010,
        PH_WRITE = 3'b100
    } dce_state_t;
endpackage : dce_pkg

`default_nettype wire

// ### dce_dma_channel_engine.sv
// Purpose: Eight-channel DMA engine with APB registers and a system bus master.
// Assumes: Requests and bus answers come from logic on i_clock.
// Notes: Items travel right-justified on the bus data lines.
`default_nettype none

module dce_dma_channel_engine
    import dce_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NUM_CH-1:0] i_dreq,
    output logic [NUM_CH-1:0] o_dack,
    output dce_bus_req_t o_bus,
    input wire logic i_bus_ack,
    input wire logic [31:0] i_bus_rdata,
    output logic [NUM_CH-1:0] o_irq
);

    // ========================================================================
    // Storage
    // ========================================================================
    dce_ctrl_t ctrl_q [NUM_CH];
    logic [31:0] pbase_q [NUM_CH];
    logic [31:0] mbase_q [NUM_CH];
    logic [CNT_W-1:0] reload_q [NUM_CH];
    logic [CNT_W-1:0] count_q [NUM_CH];
    logic [31:0] cur_p_q [NUM_CH];
    logic [31:0] cur_m_q [NUM_CH];
    logic [NUM_CH-1:0] full_flag_q;
    logic [NUM_CH-1:0] half_flag_q;
    logic [NUM_CH-1:0] dack_q;
    logic [NUM_CH-1:0] irq_q;
    dce_state_t state_q;
    logic [CH_W-1:0] sel_q;
    logic [31:0] data_q;
    dce_bus_req_t bus_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // ========================================================================
    // APB decode
    // ========================================================================
    logic apb_access;
    logic apb_wr;
    logic in_ch_space;
    logic [CH_W-1:0] apb_ch;
    logic [1:0] apb_reg;
    logic addr_ok;

    assign apb_access = i_psel && i_penable && !pready_q;
    assign apb_wr = i_psel && i_penable && pready_q && i_pwrite;
    assign in_ch_space = i_paddr < CH_SPAN_LIMIT;
    assign apb_ch = i_paddr[CH_LSB +: CH_W];
    assign apb_reg = i_paddr[REG_LSB +: 2];
    assign addr_ok = (i_paddr[1:0] == 2'h0) &&
                     (in_ch_space || i_paddr == ADDR_STATUS || i_paddr == ADDR_CLEAR);

    // One wait state; the answer is registered so outputs come from flops
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apb_access;
            pslverr_q <= apb_access && !addr_ok;
            prdata_q <= 32'h0000_0000;
            if (apb_access && !i_pwrite && addr_ok) begin
                if (in_ch_space) begin
                    case (apb_reg)
                        REG_CTRL: prdata_q <= {17'h00000, ctrl_q[apb_ch]};
                        REG_PBASE: prdata_q <= pbase_q[apb_ch];
                        REG_MBASE: prdata_q <= mbase_q[apb_ch];
                        default: prdata_q <= {16'h0000, count_q[apb_ch]};
                    endcase
                end else if (i_paddr == ADDR_STATUS) begin
                    prdata_q <= {16'h0000, half_flag_q, full_flag_q};
                end
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;

    // ========================================================================
    // Arbitration
    // ========================================================================
    logic [NUM_CH-1:0] pend;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_pend
            // Acknowledged channel waits for its request to drop
            assign pend[g] = ctrl_q[g].enable && (count_q[g] != '0) && !dack_q[g] &&
                             (ctrl_q[g].memory_copy_mode || i_dreq[g]);
        end
    endgenerate

    logic found;
    logic [CH_W-1:0] win;

    always_comb begin
        found = 1'b0;
        win = '0;
        for (int lvl = 3; lvl >= 0; lvl--) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (!found && pend[ch] && ctrl_q[ch].priority_level == 2'(lvl)) begin
                    found = 1'b1;
                    win = CH_W'(ch);
                end
            end
        end
    end

    // ========================================================================
    // Item datapath
    // ========================================================================
    function automatic logic [31:0] fit(input logic [31:0] d, input logic [1:0] w);
        case (w)
            WID_BYTE: fit = {24'h000000, d[7:0]};
            WID_HALF: fit = {16'h0000, d[15:0]};
            default: fit = d;
        endcase
    endfunction : fit

    function automatic logic [31:0] step(input logic [1:0] w);
        case (w)
            WID_BYTE: step = 32'h0000_0001;
            WID_HALF: step = 32'h0000_0002;
            default: step = 32'h0000_0004;
        endcase
    endfunction : step

    dce_ctrl_t wc;
    dce_ctrl_t sc;
    logic [1:0] win_src_w;
    logic [1:0] sel_src_w;
    logic [1:0] sel_dst_w;
    logic item_done;

    assign wc = ctrl_q[win];
    assign sc = ctrl_q[sel_q];
    assign win_src_w = wc.from_memory ? wc.mem_width : wc.periph_width;
    assign sel_src_w = sc.from_memory ? sc.mem_width : sc.periph_width;
    assign sel_dst_w = sc.from_memory ? sc.periph_width : sc.mem_width;
    assign item_done = (state_q == PH_WRITE) && i_bus_ack;

    // ========================================================================
    // Transfer sequencer
    // ========================================================================
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= PH_IDLE;
            sel_q <= '0;
            data_q <= 32'h0000_0000;
            bus_q <= '0;
        end else begin
            case (state_q)
                PH_IDLE: begin
                    if (found) begin
                        sel_q <= win;
                        bus_q.req <= 1'b1;
                        bus_q.write <= 1'b0;
                        bus_q.size <= win_src_w;
                        bus_q.addr <= wc.from_memory ? cur_m_q[win] : cur_p_q[win];
                        bus_q.wdata <= 32'h0000_0000;
                        state_q <= PH_READ;
                    end
                end
                PH_READ: begin
                    if (i_bus_ack) begin
                        // Source masked first, then cut to the destination size
                        data_q <= fit(fit(i_bus_rdata, sel_src_w), sel_dst_w);
                        bus_q.write <= 1'b1;
                        bus_q.size <= sel_dst_w;
                        bus_q.addr <= sc.from_memory ? cur_p_q[sel_q] : cur_m_q[sel_q];
                        bus_q.wdata <= fit(fit(i_bus_rdata, sel_src_w), sel_dst_w);
                        state_q <= PH_WRITE;
                    end
                end
                PH_WRITE: begin
                    if (i_bus_ack) begin
                        bus_q <= '0;
                        state_q <= PH_IDLE;
                    end
                end
                default: begin
                    bus_q <= '0;
                    state_q <= PH_IDLE;
                end
            endcase
        end
    end

    assign o_bus = bus_q;

    // ========================================================================
    // Peripheral acknowledge
    // ========================================================================
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            dack_q <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (state_q == PH_IDLE && found && win == CH_W'(ch) &&
                    !ctrl_q[ch].memory_copy_mode) begin
                    dack_q[ch] <= 1'b1;
                end else if (!i_dreq[ch]) begin
                    dack_q[ch] <= 1'b0;
                end
            end
        end
    end

    assign o_dack = dack_q;

    // ========================================================================
    // Channel registers and working state
    // ========================================================================
    logic [CNT_W-1:0] next_cnt;
    assign next_cnt = count_q[sel_q] - CNT_W'(1);

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                ctrl_q[ch] <= CTRL_RESET;
                pbase_q[ch] <= 32'h0000_0000;
                mbase_q[ch] <= 32'h0000_0000;
                reload_q[ch] <= '0;
                count_q[ch] <= '0;
                cur_p_q[ch] <= 32'h0000_0000;
                cur_m_q[ch] <= 32'h0000_0000;
            end
        end else begin
            // Disabling only clears the enable bit; nothing else resets
            // Misaligned writes are refused and must not land
            if (apb_wr && in_ch_space && addr_ok) begin
                case (apb_reg)
                    REG_CTRL: begin
                        ctrl_q[apb_ch] <= i_pwdata[CTRL_W-1:0];
                        if (i_pwdata[0] && !ctrl_q[apb_ch].enable) begin
                            cur_p_q[apb_ch] <= pbase_q[apb_ch];
                            cur_m_q[apb_ch] <= mbase_q[apb_ch];
                        end
                    end
                    REG_PBASE: pbase_q[apb_ch] <= i_pwdata;
                    REG_MBASE: mbase_q[apb_ch] <= i_pwdata;
                    default: begin
                        // Loading while enabled is a software fault; the value still lands
                        reload_q[apb_ch] <= i_pwdata[CNT_W-1:0];
                        count_q[apb_ch] <= i_pwdata[CNT_W-1:0];
                    end
                endcase
            end
            if (item_done) begin
                if (next_cnt == '0 && sc.wraparound_on) begin
                    count_q[sel_q] <= reload_q[sel_q];
                    cur_p_q[sel_q] <= pbase_q[sel_q];
                    cur_m_q[sel_q] <= mbase_q[sel_q];
                end else begin
                    count_q[sel_q] <= next_cnt;
                    if (sc.periph_addr_step) begin
                        cur_p_q[sel_q] <= cur_p_q[sel_q] + step(sc.periph_width);
                    end
                    if (sc.mem_addr_step) begin
                        cur_m_q[sel_q] <= cur_m_q[sel_q] + step(sc.mem_width);
                    end
                end
            end
        end
    end

    // ========================================================================
    // Event flags and interrupt lines
    // ========================================================================
    logic clr_wr;
    assign clr_wr = apb_wr && i_paddr == ADDR_CLEAR;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            full_flag_q <= '0;
            half_flag_q <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                // A set in the same cycle as a clear wins
                if (item_done && sel_q == CH_W'(ch) && next_cnt == '0) begin
                    full_flag_q[ch] <= 1'b1;
                end else if (clr_wr && i_pwdata[ch]) begin
                    full_flag_q[ch] <= 1'b0;
                end
                if (item_done && sel_q == CH_W'(ch) &&
                    next_cnt == (reload_q[ch] >> 1)) begin
                    half_flag_q[ch] <= 1'b1;
                end else if (clr_wr && i_pwdata[HALF_LSB + ch]) begin
                    half_flag_q[ch] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_q <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                irq_q[ch] <= (full_flag_q[ch] && ctrl_q[ch].full_done_irq_on) ||
                             (half_flag_q[ch] && ctrl_q[ch].half_done_irq_on);
            end
        end
    end

    assign o_irq = irq_q;

endmodule : dce_dma_channel_engine

`default_nettype wire

// ### dce_bus_slave.sv
// Purpose: System bus slave model for the DMA engine bench.
// Assumes: Requests held until ack; ack is a one-cycle pulse.
// Notes: Read data is a function of the address; writes are logged.
`default_nettype none

module dce_bus_slave
    import dce_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire dce_bus_req_t i_bus,
    input wire logic [3:0] i_wait,
    output logic o_ack,
    output logic [31:0] o_rdata,
    output logic [31:0] o_waddr,
    output logic [31:0] o_wdata,
    output logic [15:0] o_wcnt
);
    // ==========================================
    // Answer
    logic [3:0] cnt_q;
    logic [31:0] word;
    // Every byte lane differs, so a missing mask shows
    assign word = {4{i_bus.addr[7:0]}} ^ 32'h5ac33ca5;
    // Off the ack cycle the lines carry the inverse, never a stale copy
    assign o_rdata = o_ack ? word : ~word;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= 4'h0;
            o_ack <= 1'b0;
        end else if (o_ack) begin
            cnt_q <= 4'h0;
            o_ack <= 1'b0;
        end else if (i_bus.req && cnt_q >= i_wait) begin
            o_ack <= 1'b1;
        end else if (i_bus.req) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wcnt <= 16'h0;
            o_waddr <= 32'h0;
            o_wdata <= 32'h0;
        end else if (o_ack && i_bus.write) begin
            o_wcnt <= o_wcnt + 16'h1;
            o_waddr <= i_bus.addr;
            o_wdata <= i_bus.wdata;
        end
    end
endmodule : dce_bus_slave

`default_nettype wire

// ### dce_dma_channel_engine_chk.sv
// Purpose: Port assertions for the DMA engine.
// Assumes: One clock, reset active low.
// Notes: Attached to every engine instance by bind.
`default_nettype none

module dce_dma_channel_engine_chk
    import dce_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [NUM_CH-1:0] i_dreq,
    input wire logic [NUM_CH-1:0] o_dack,
    input wire dce_bus_req_t o_bus,
    input wire logic i_bus_ack,
    input wire logic [31:0] i_bus_rdata,
    input wire logic [NUM_CH-1:0] o_irq
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    logic acc1;
    // First access cycle only; the answer comes one cycle later
    assign acc1 = i_psel && i_penable && !o_pready;
    a_apb_wait: assert property (acc1 |=> o_pready)
        else $error("pready not in second access cycle");
    a_apb_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (acc1 && i_paddr >= 12'h088 |=> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    a_read_write: assert property (o_bus.req && !o_bus.write && i_bus_ack |=> o_bus.req && o_bus.write)
        else $error("read not followed by write");
    a_write_end: assert property (o_bus.req && o_bus.write && i_bus_ack |=> !o_bus.req)
        else $error("request kept after write");
    a_bus_hold: assert property (o_bus.req && !i_bus_ack |=> $stable(o_bus))
        else $error("bus request changed before ack");
    a_byte_zero: assert property (o_bus.req && o_bus.write && o_bus.size == WID_BYTE |-> o_bus.wdata[31:8] == 24'h0)
        else $error("byte write not zero above");
    a_half_zero: assert property (o_bus.req && o_bus.write && o_bus.size == WID_HALF |-> o_bus.wdata[31:16] == 16'h0)
        else $error("halfword write not zero above");
    a_dack_rise: assert property ((o_dack & ~$past(o_dack)) != 8'h0 |-> $rose(o_bus.req))
        else $error("acknowledge without bus access");
    a_dack_drop: assert property ((o_dack & ~i_dreq) != 8'h0 |=> (o_dack & ~$past(i_dreq)) == 8'h0)
        else $error("acknowledge held after request removed");
endmodule : dce_dma_channel_engine_chk

bind dce_dma_channel_engine dce_dma_channel_engine_chk u_chk (.i_clock, .i_resetn, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_dreq,
    .o_dack, .o_bus, .i_bus_ack, .i_bus_rdata, .o_irq);

`default_nettype wire

// ### dce_dma_channel_engine_test.sv
// Purpose: Self-checking bench for the DMA engine.
// Assumes: APB master and peripheral requests driven at rising edges.
// Notes: Width rows run in a loop; wrap, copy and priority by hand.
`default_nettype none

module dce_dma_channel_engine_test
    import dce_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [2:0] ch;
        logic [3:0] n;
        dce_ctrl_t c;
    } dce_row_t;
    logic i_clock, i_resetn, psel, penable, pwrite, pready, pslverr, ack, re, si, di;
    logic [AW-1:0] paddr, b;
    logic [31:0] pwdata, prdata, rdata, waddr, wdata, rq, pb, mb, s, d;
    logic [7:0] dreq, dack, irq;
    logic [15:0] wcnt, n0;
    logic [3:0] wt;
    logic [1:0] sw, dw;
    dce_bus_req_t bus;
    dce_row_t rw;
    dce_ctrl_t c;
    int n_errors, samples_checked;
    // Widths byte/half/word crossed, fixed side, peripheral as source except the last row (memory as source)
    dce_row_t rows[5] = '{'{3'h0, 4'h4, 15'h04c6}, '{3'h1, 4'h4, 15'h08c6},
        '{3'h2, 4'h4, 15'h01c6}, '{3'h3, 4'h3, 15'h0a86}, '{3'h7, 4'h2, 15'h09d6}};

    dce_dma_channel_engine u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_dreq(dreq),
        .o_dack(dack), .o_bus(bus), .i_bus_ack(ack), .i_bus_rdata(rdata), .o_irq(irq));
    dce_bus_slave u_slave (.i_clock(i_clock), .i_resetn(i_resetn), .i_bus(bus), .i_wait(wt),
        .o_ack(ack), .o_rdata(rdata), .o_waddr(waddr), .o_wdata(wdata), .o_wcnt(wcnt));

    // ==========================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] v);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock);
    endtask : apb
    task automatic setup(input logic [2:0] ch, input logic [31:0] p, m, input logic [15:0] n,
        input dce_ctrl_t k);
        b = AW'(ch) << CH_LSB;
        apb(1'b1, b + 12'h4, p);
        apb(1'b1, b + 12'h8, m);
        apb(1'b1, b + 12'hc, {16'h0, n});
        apb(1'b1, b, 32'(k));
        k.enable = 1'b1;
        apb(1'b1, b, 32'(k));
    endtask : setup
    // Peripheral holds its request until acknowledged
    task automatic item(input logic [2:0] ch, input logic [31:0] ea, ed);
        n0 = wcnt;
        dreq[ch] <= 1'b1;
        while (dack[ch] !== 1'b1) @(posedge i_clock);
        dreq[ch] <= 1'b0;
        while (wcnt == n0 || dack[ch] !== 1'b0) @(posedge i_clock);
        chk("write addr", ea, waddr);
        chk("write data", ed, wdata);
    endtask : item
    function automatic logic [31:0] sword(input logic [31:0] a, input logic [1:0] w);
        return ({4{a[7:0]}} ^ 32'h5ac33ca5) & (w == 2'h0 ? 32'hff : w == 2'h1 ? 32'hffff : '1);
    endfunction : sword
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // ==========================================
    // Clock, reset, watchdog
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        repeat (30000) @(posedge i_clock);
        n_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        final_report();
    end

    // ==========================================
    // Tests
    initial begin
        {i_resetn, psel, penable, pwrite, paddr, pwdata, dreq, wt} = '0;
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'(CTRL_RESET), rq);
        foreach (rows[r]) begin
            rw = rows[r];
            c = rw.c;
            wt <= 4'(r * 2); // Slave wait grows by two cycles per row, from prompt to slow
            pb = 32'h1000 + (32'(rw.ch) << 8);
            mb = pb + 32'h1000;
            setup(rw.ch, pb, mb, 16'(rw.n), c);
            s = c.from_memory ? mb : pb;
            d = c.from_memory ? pb : mb;
            sw = c.from_memory ? c.mem_width : c.periph_width;
            dw = c.from_memory ? c.periph_width : c.mem_width;
            si = c.from_memory ? c.mem_addr_step : c.periph_addr_step;
            di = c.from_memory ? c.periph_addr_step : c.mem_addr_step;
            for (int i = 0; i < rw.n; i++) begin
                item(rw.ch, d, sword(s, sw < dw ? sw : dw));
                s += si ? 32'h1 << sw : 32'h0;
                d += di ? 32'h1 << dw : 32'h0;
            end
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("status", 32'h101 << rw.ch, rq);
            chk("irq", 32'h1, 32'(irq[rw.ch]));
            apb(1'b0, b + 12'hc, 32'h0);
            chk("count", 32'h0, rq);
            n0 = wcnt;
            dreq[rw.ch] <= 1'b1;
            repeat (20) @(posedge i_clock);
            dreq <= 8'h0;
            chk("served at zero", 32'(n0), 32'(wcnt));
            apb(1'b1, ADDR_CLEAR, 32'h101 << rw.ch);
            apb(1'b1, b, 32'(c));
            apb(1'b0, b + 12'h4, 32'h0);
            chk("base kept", pb, rq);
        end
        c = 15'h0ae0;
        setup(3'h4, 32'h3000, 32'h3100, 16'h2, c);
        item(3'h4, 32'h3100, sword(32'h3000, 2'h2));
        item(3'h4, 32'h3104, sword(32'h3004, 2'h2));
        apb(1'b0, 12'h04c, 32'h0);
        chk("wrap count", 32'h2, rq);
        item(3'h4, 32'h3100, sword(32'h3000, 2'h2));
        apb(1'b1, 12'h040, 32'(c));
        c = 15'h4ac0;
        n0 = wcnt;
        setup(3'h5, 32'h4000, 32'h4100, 16'h3, c);
        while (wcnt !== n0 + 16'h3) @(posedge i_clock);
        repeat (20) @(posedge i_clock);
        chk("copy items", 32'(n0 + 16'h3), 32'(wcnt));
        chk("copy last", 32'h4108, waddr);
        chk("copy dack", 32'h0, 32'(dack));
        c = 15'h0a00;
        setup(3'h1, 32'h5000, 32'h5100, 16'h1, c);
        c.priority_level = 2'h2;
        setup(3'h6, 32'h5200, 32'h5300, 16'h1, c);
        dreq <= 8'h42;
        while (dack === 8'h0) @(posedge i_clock);
        chk("level win", 32'h40, 32'(dack));
        dreq <= 8'h0;
        while (dack !== 8'h0) @(posedge i_clock);
        c.priority_level = 2'h1;
        setup(3'h2, 32'h5400, 32'h5500, 16'h1, c);
        setup(3'h3, 32'h5600, 32'h5700, 16'h1, c);
        dreq <= 8'h0c;
        while (dack === 8'h0) @(posedge i_clock);
        chk("index win", 32'h4, 32'(dack));
        dreq <= 8'h0;
        while (dack !== 8'h0) @(posedge i_clock);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped err", 32'h1, 32'(re));
        chk("unmapped data", 32'h0, rq);
        final_report();
    end
endmodule : dce_dma_channel_engine_test

`default_nettype wire
